//--- src/ccs_pkg.sv
// constants, register map and types of the clock set-up sequencer
// assumes a 200 MHz system clock and an Avalon-MM master reaching the registers
//
// Operation
// RULE_01 - far party keeps the needed clocks running
// RULE_02 - shutdown pin held low 1 ms to reset
// RULE_03 - wait 1 ms after shutdown release
// RULE_04 - references powered before any other block works; ext master bit and frame clock generation here runs without ref_ready
// RULE_05 - allow 5.0 ms for reference power-up
// RULE_06 - program clock and format fields during power-up
// RULE_07 - pll starts on enable rise with reference
// RULE_08 - pll master locks within 3 ms
// RULE_09 - pll master holds bit/frame clocks low
// RULE_10 - pll master drives clocks once locked
// RULE_11 - master clock out may be invalid pre-lock
// RULE_12 - master clock out correct after lock
// RULE_13 - far party sets master clock out enable
// RULE_14 - far party supplies bit clock as reference
// RULE_15 - bit clock referenced pll locks within 3 ms
// RULE_16 - far party syncs clocks to master clock out
// RULE_17 - external slave runs once all clocks present
// RULE_18 - external master drives clocks after select bits
// RULE_19 - shutdown low returns all registers to default
// RULE_20 - pll enable ignored without toggling reference
package ccs_pkg;
    // timing, each time in microseconds and its cycle count
    localparam int CLK_MHZ       = 200;
    localparam int CORE_WAIT_US  = 1000;
    localparam int REF_UP_US     = 5000;
    localparam int LOCK_MAX_US   = 3000;
    localparam int CORE_WAIT_CYC = CORE_WAIT_US * CLK_MHZ;
    localparam int REF_UP_CYC    = REF_UP_US * CLK_MHZ;
    localparam int LOCK_MAX_CYC  = LOCK_MAX_US * CLK_MHZ;
    localparam int PLL_LOCK_CYC  = LOCK_MAX_CYC / 2;
    // clock activity and divider counts
    localparam logic [11:0] ACT_TIMEOUT  = 12'h0800;
    localparam logic [1:0]  SYS_TICK_MAX = 2'h3;
    localparam logic [1:0]  BCLK_HALF_MAX = 2'h1;
    localparam logic [4:0]  LRCK_HALF_MAX = 5'h1f;
    // register byte offsets
    localparam logic [4:0] OFS_POWER   = 5'h00;
    localparam logic [4:0] OFS_CLOCK   = 5'h04;
    localparam logic [4:0] OFS_FORMAT  = 5'h08;
    localparam logic [4:0] OFS_DIVIDER = 5'h0c;
    localparam logic [4:0] OFS_STATUS  = 5'h10;
    // power register bits
    localparam int BIT_REF_EN = 0;
    localparam int BIT_PLL_EN = 1;
    localparam int BIT_MASTER_CLOCK_OUT_ENABLE  = 2;
    localparam int BIT_MSEL   = 3;
    localparam int BIT_BIT_CLOCK_RATE_SELECT   = 4;
    // clock register fields
    localparam int BIT_PLL_REF = 0;
    localparam int BIT_PLL_MD  = 1;
    localparam int POS_RATIO   = 2;
    localparam int POS_RATE    = 4;
    // format register fields
    localparam int POS_FMT  = 0;
    localparam int POS_DLEN = 2;
    localparam int BIT_BPOL = 4;
    localparam int BIT_SO2E = 5;
    // divider register fields
    localparam int POS_DIV_IN = 0;
    localparam int POS_DIV_FB = 16;
    // clocking modes and pll states
    typedef enum logic [2:0] {
        MODE_PLL_MASTER, MODE_PLL_SLAVE_BCLK, MODE_PLL_SLAVE_MCLK,
        MODE_EXT_SLAVE, MODE_EXT_MASTER
    } ccs_mode_e;
    typedef enum logic [1:0] {PLL_OFF, PLL_ARMED, PLL_LOCKING, PLL_LOCKED} ccs_pll_e;
endpackage

//--- src/ccs_top.sv
// clock set-up sequencer: reset wait, reference power-up, pll, clock pins
// assumes Avalon-MM master on clk_sys_in; clock pins arrive asynchronously
`timescale 1ns/100ps
`default_nettype none
module ccs_top #(
    parameter int unsigned CORE_WAIT_CYC = ccs_pkg::CORE_WAIT_CYC,
    parameter int unsigned REF_UP_CYC    = ccs_pkg::REF_UP_CYC,
    parameter int unsigned PLL_LOCK_CYC  = ccs_pkg::PLL_LOCK_CYC,
    parameter int unsigned LOCK_MAX_CYC  = ccs_pkg::LOCK_MAX_CYC
) (
    // clock and reset
    input  wire logic        clk_sys_in,
    input  wire logic        rst_n_in,
    // register bus
    input  wire logic [4:0]  avs_address_in,
    input  wire logic        avs_read_in,
    input  wire logic        avs_write_in,
    input  wire logic [31:0] avs_writedata_in,
    output logic      [31:0] avs_readdata_out,
    output logic             avs_waitrequest_out,
    // device pins
    input  wire logic        chip_shutdown_pin_n_in,
    input  wire logic        master_clock_input_in,
    input  wire logic        bclk_in,
    input  wire logic        lrck_in,
    output logic             bclk_out,
    output logic             bclk_oe_out,
    output logic             lrck_out,
    output logic             lrck_oe_out,
    output logic             master_clock_output_out,
    output logic             normal_operation_out
);
    // ************************************************************
    // pin synchronisers and clock activity
    // ************************************************************
    logic [3:0]  sync1, sync2, sync3;
    logic [2:0]  clk_seen;           // mclk, bclk, lrck present
    logic [11:0] act_cnt [3];

    // two flops, then a history flop for edges
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            sync1 <= 4'h0;
            sync2 <= 4'h0;
            sync3 <= 4'h0;
        end else begin
            sync1 <= {lrck_in, bclk_in, master_clock_input_in, chip_shutdown_pin_n_in};
            sync2 <= sync1;
            sync3 <= sync2;
        end
    end

    // a clock counts as supplied while it keeps toggling
    for (genvar i = 0; i < 3; i++) begin : g_act
        always_ff @(posedge clk_sys_in) begin
            if (!rst_n_in)
                act_cnt[i] <= ccs_pkg::ACT_TIMEOUT;
            else if (sync2[i+1] != sync3[i+1])
                act_cnt[i] <= 12'h000;
            else if (act_cnt[i] != ccs_pkg::ACT_TIMEOUT)
                act_cnt[i] <= act_cnt[i] + 12'h001;
        end
        assign clk_seen[i] = (act_cnt[i] != ccs_pkg::ACT_TIMEOUT);
    end
    wire mclk_rise = sync2[1] & ~sync3[1];

    // ************************************************************
    // core regulator wait after shutdown release
    // ************************************************************
    logic [20:0] core_cnt;
    logic        core_ready;

    // shutdown low holds the core in reset
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in || !sync2[0]) begin
            core_cnt   <= 21'h0;
            core_ready <= 1'b0;
        end else if (!core_ready) begin
            if (core_cnt == 21'(CORE_WAIT_CYC - 1))
                core_ready <= 1'b1;
            else
                core_cnt <= core_cnt + 21'h1;
        end
    end

    // ************************************************************
    // register file, one wait state per access
    // ************************************************************
    logic        ack;
    logic        refen, pllen, master_clock_out_enable, msel, bit_clock_rate_select;
    logic        pll_ref_sel, pll_mode, bpol, so2e;
    logic [1:0]  ratio, fmt, dlen;
    logic [3:0]  rate;
    logic [15:0] div_in, div_fb;
    logic [31:0] status;
    wire req = avs_read_in | avs_write_in;
    wire wr_take = avs_write_in & ack & core_ready;
    assign avs_waitrequest_out = req & ~ack;

    // answer on the second cycle of a request
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in)
            ack <= 1'b0;
        else
            ack <= req & ~ack;
    end

    // config held at default while shutdown or core wait [RULE_19]
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in || !core_ready) begin
            {refen, pllen, master_clock_out_enable, msel, bit_clock_rate_select} <= 5'h00;
            {pll_ref_sel, pll_mode, bpol, so2e} <= 4'h0;
            {ratio, fmt, dlen} <= 6'h00;
            rate   <= 4'h0;
            div_in <= 16'h0000;
            div_fb <= 16'h0000;
        end else if (wr_take) begin
            unique case (avs_address_in)
                ccs_pkg::OFS_POWER: begin
                    refen <= avs_writedata_in[ccs_pkg::BIT_REF_EN];
                    pllen <= avs_writedata_in[ccs_pkg::BIT_PLL_EN];
                    master_clock_out_enable <= avs_writedata_in[ccs_pkg::BIT_MASTER_CLOCK_OUT_ENABLE];
                    msel  <= avs_writedata_in[ccs_pkg::BIT_MSEL];
                    bit_clock_rate_select  <= avs_writedata_in[ccs_pkg::BIT_BIT_CLOCK_RATE_SELECT];
                end
                ccs_pkg::OFS_CLOCK: begin
                    pll_ref_sel <= avs_writedata_in[ccs_pkg::BIT_PLL_REF];
                    pll_mode    <= avs_writedata_in[ccs_pkg::BIT_PLL_MD];
                    ratio       <= avs_writedata_in[ccs_pkg::POS_RATIO +: 2];
                    rate        <= avs_writedata_in[ccs_pkg::POS_RATE +: 4];
                end
                ccs_pkg::OFS_FORMAT: begin
                    fmt  <= avs_writedata_in[ccs_pkg::POS_FMT +: 2];
                    dlen <= avs_writedata_in[ccs_pkg::POS_DLEN +: 2];
                    bpol <= avs_writedata_in[ccs_pkg::BIT_BPOL];
                    so2e <= avs_writedata_in[ccs_pkg::BIT_SO2E];
                end
                ccs_pkg::OFS_DIVIDER: begin
                    div_in <= avs_writedata_in[ccs_pkg::POS_DIV_IN +: 16];
                    div_fb <= avs_writedata_in[ccs_pkg::POS_DIV_FB +: 16];
                end
                default: ;
            endcase
        end
    end

    // read data latched in the wait cycle, zero when unmapped
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in)
            avs_readdata_out <= 32'h0000_0000;
        else if (avs_read_in && !ack) begin
            unique case (avs_address_in)
                ccs_pkg::OFS_POWER:   avs_readdata_out <= {27'h0, bit_clock_rate_select, msel, master_clock_out_enable, pllen, refen};
                ccs_pkg::OFS_CLOCK:   avs_readdata_out <= {24'h0, rate, ratio, pll_mode, pll_ref_sel};
                ccs_pkg::OFS_FORMAT:  avs_readdata_out <= {26'h0, so2e, bpol, dlen, fmt};
                ccs_pkg::OFS_DIVIDER: avs_readdata_out <= {div_fb, div_in};
                ccs_pkg::OFS_STATUS:  avs_readdata_out <= status;
                default:              avs_readdata_out <= 32'h0000_0000;
            endcase
        end
    end

    // ************************************************************
    // reference power-up
    // ************************************************************
    logic [20:0] ref_cnt;
    logic        ref_ready;

    // references ready a fixed time after enable [RULE_04]
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in || !refen) begin
            ref_cnt   <= 21'h0;
            ref_ready <= 1'b0;
        end else if (!ref_ready) begin
            if (ref_cnt == 21'(REF_UP_CYC - 1))
                ref_ready <= 1'b1;
            else
                ref_cnt <= ref_cnt + 21'h1;
        end
    end

    // ************************************************************
    // mode decode and pll sequencing
    // ************************************************************
    ccs_pkg::ccs_mode_e mode;
    ccs_pkg::ccs_pll_e  pll_state;
    logic [20:0] lock_cnt;
    logic        pllen_q, ref_present;

    // clocking mode from select bits
    always_comb begin
        if (pllen)
            mode = msel ? ccs_pkg::MODE_PLL_MASTER :
                   (pll_ref_sel ? ccs_pkg::MODE_PLL_SLAVE_BCLK : ccs_pkg::MODE_PLL_SLAVE_MCLK);
        else
            mode = msel ? ccs_pkg::MODE_EXT_MASTER : ccs_pkg::MODE_EXT_SLAVE;
        ref_present = (mode == ccs_pkg::MODE_PLL_SLAVE_BCLK) ? clk_seen[1] : clk_seen[0];
    end

    // pll: arm on enable rise, lock only with references and clock
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            pll_state <= ccs_pkg::PLL_OFF;
            pllen_q   <= 1'b0;
        end else begin
            pllen_q <= pllen;
            unique case (pll_state)
                ccs_pkg::PLL_OFF:
                    if (pllen && !pllen_q) pll_state <= ccs_pkg::PLL_ARMED;   // [RULE_07]
                ccs_pkg::PLL_ARMED:
                    if (!pllen) pll_state <= ccs_pkg::PLL_OFF;
                    else if (ref_ready && ref_present)
                        pll_state <= ccs_pkg::PLL_LOCKING;                    // [RULE_07] [RULE_20]
                ccs_pkg::PLL_LOCKING:
                    if (!pllen) pll_state <= ccs_pkg::PLL_OFF;
                    else if (!ref_ready || !ref_present) pll_state <= ccs_pkg::PLL_ARMED;
                    else if (lock_cnt == 21'(PLL_LOCK_CYC - 1))
                        pll_state <= ccs_pkg::PLL_LOCKED;                     // [RULE_08] [RULE_15]
                ccs_pkg::PLL_LOCKED:
                    if (!pllen) pll_state <= ccs_pkg::PLL_OFF;
                    else if (!ref_ready || !ref_present) pll_state <= ccs_pkg::PLL_ARMED;
            endcase
        end
    end

    // lock timer runs only while locking
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in || pll_state != ccs_pkg::PLL_LOCKING)
            lock_cnt <= 21'h0;
        else
            lock_cnt <= lock_cnt + 21'h1;
    end

    // ************************************************************
    // bit and frame clock generation
    // ************************************************************
    logic [1:0] tick_cnt, half_cnt;
    logic [4:0] lrck_cnt;
    logic       bclk_q, lrck_q, gen_run, tick;
    wire pll_running = (pll_state == ccs_pkg::PLL_LOCKING) || (pll_state == ccs_pkg::PLL_LOCKED);
    assign gen_run = (mode == ccs_pkg::MODE_PLL_MASTER && pll_state == ccs_pkg::PLL_LOCKED)
                   || (mode == ccs_pkg::MODE_EXT_MASTER && bit_clock_rate_select && clk_seen[0]); // [RULE_10] [RULE_18]
    assign tick = (mode == ccs_pkg::MODE_PLL_MASTER) ? (tick_cnt == ccs_pkg::SYS_TICK_MAX)
                                                     : mclk_rise;

    // pll output divider standing in for the locked vco
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in || !gen_run)
            tick_cnt <= 2'h0;
        else
            tick_cnt <= tick_cnt + 2'h1;
    end

    // bclk half period of two ticks, lrck every 32 bclk periods
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in || !gen_run) begin
            half_cnt <= 2'h0;
            lrck_cnt <= 5'h00;
            bclk_q   <= 1'b0;
            lrck_q   <= 1'b0;
        end else if (tick) begin
            if (half_cnt == ccs_pkg::BCLK_HALF_MAX) begin
                half_cnt <= 2'h0;
                bclk_q   <= ~bclk_q;
                if (bclk_q) begin
                    lrck_cnt <= lrck_cnt + 5'h01;
                    if (lrck_cnt == ccs_pkg::LRCK_HALF_MAX) lrck_q <= ~lrck_q;
                end
            end else begin
                half_cnt <= half_cnt + 2'h1;
            end
        end
    end

    // pins low until generation runs, driven in master modes [RULE_09]
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in) begin
            bclk_out    <= 1'b0;
            lrck_out    <= 1'b0;
            bclk_oe_out <= 1'b0;
            lrck_oe_out <= 1'b0;
        end else begin
            bclk_out    <= gen_run & (bclk_q ^ bpol);
            lrck_out    <= gen_run & lrck_q;
            bclk_oe_out <= msel & core_ready;
            lrck_oe_out <= msel & core_ready;
        end
    end

    // ************************************************************
    // master clock output and status
    // ************************************************************
    logic mck_q, mck_div;

    // fast toggle before lock, half rate once locked [RULE_11] [RULE_12]
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in || !(master_clock_out_enable && pll_running)) begin
            mck_q   <= 1'b0;
            mck_div <= 1'b0;
            master_clock_output_out <= 1'b0;
        end else begin
            mck_div <= ~mck_div;
            if (pll_state != ccs_pkg::PLL_LOCKED || mck_div) mck_q <= ~mck_q;
            master_clock_output_out <= mck_q;
        end
    end

    // normal operation per mode [RULE_17]
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in)
            normal_operation_out <= 1'b0;
        else if (mode == ccs_pkg::MODE_EXT_SLAVE)
            normal_operation_out <= ref_ready && clk_seen == 3'h7;
        else if (mode == ccs_pkg::MODE_EXT_MASTER)
            normal_operation_out <= ref_ready && gen_run;
        else
            normal_operation_out <= ref_ready && pll_state == ccs_pkg::PLL_LOCKED;
    end
    assign status = {21'h0, mode, clk_seen, normal_operation_out,
                     pll_state == ccs_pkg::PLL_LOCKED, pll_running, ref_ready, core_ready};

    // ************************************************************
    // assertions
    // ************************************************************
    logic [21:0] lock_age;
    always_ff @(posedge clk_sys_in) begin
        if (!rst_n_in || pll_state != ccs_pkg::PLL_LOCKING)
            lock_age <= 22'h0;
        else
            lock_age <= lock_age + 22'h1;
    end
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (!rst_n_in);

    a_pll_start_ref: assert property ($rose(pll_state == ccs_pkg::PLL_LOCKING) // [RULE_07]
        |-> $past(ref_ready && ref_present && pllen)) else $error("pll started without ref");
    a_lock_time_max: assert property (lock_age <= 22'(LOCK_MAX_CYC)) // [RULE_08] [RULE_15]
        else $error("pll lock too slow");
    a_refs_first: assert property (pll_running |-> $past(ref_ready)) // [RULE_04]
        else $error("pll ran before references");
    a_prelock_low: assert property (mode == ccs_pkg::MODE_PLL_MASTER // [RULE_09]
        && pll_state != ccs_pkg::PLL_LOCKED && core_ready
        |=> bclk_oe_out && !bclk_out && !lrck_out) else $error("clock pins not low before lock");
    a_clock_starts: assert property ((mode == ccs_pkg::MODE_PLL_MASTER // [RULE_10]
        && pll_state == ccs_pkg::PLL_LOCKED)[*8] |-> ##[0:12] $changed(bclk_out))
        else $error("bclk idle after lock");
    a_master_clock_output_locked: assert property ((pll_state == ccs_pkg::PLL_LOCKED && master_clock_out_enable)[*4] // [RULE_12]
        |-> master_clock_output_out != $past(master_clock_output_out, 2))
        else $error("master clock out wrong after lock");
    a_master_clock_output_quiet: assert property (!(master_clock_out_enable && pll_running) // [RULE_11]
        |=> !master_clock_output_out) else $error("master clock out while disabled");
    // normal op is registered, so it judges the mode of the cycle before
    a_slave_gate: assert property (normal_operation_out // [RULE_17]
        && mode == ccs_pkg::MODE_EXT_SLAVE && $past(mode == ccs_pkg::MODE_EXT_SLAVE)
        |-> $past(clk_seen == 3'h7)) else $error("slave ran without clocks");
    a_ext_master_wait: assert property (mode == ccs_pkg::MODE_EXT_MASTER && !bit_clock_rate_select // [RULE_18]
        |=> !bclk_out && !lrck_out) else $error("ext master drove clocks early");
    // config clears two cycles after the pin, the pll one cycle later
    a_shutdown_clear: assert property (!sync2[0] ##1 1'b1 // [RULE_19]
        |=> !refen && !pllen && !msel ##1 pll_state != ccs_pkg::PLL_LOCKED)
        else $error("shutdown kept config");
    a_no_ref_hold: assert property (pll_state == ccs_pkg::PLL_ARMED && !ref_present // [RULE_20]
        |=> pll_state != ccs_pkg::PLL_LOCKING) else $error("pll armed without ref");

    c_master_lock: cover property (mode == ccs_pkg::MODE_PLL_MASTER
        && $rose(pll_state == ccs_pkg::PLL_LOCKED));
    c_bclk_lock: cover property (mode == ccs_pkg::MODE_PLL_SLAVE_BCLK
        && $rose(pll_state == ccs_pkg::PLL_LOCKED));
    c_slave_run: cover property (mode == ccs_pkg::MODE_EXT_SLAVE && $rose(normal_operation_out));
    c_ext_master: cover property (mode == ccs_pkg::MODE_EXT_MASTER && $rose(lrck_out));
endmodule // ccs_top
`default_nettype wire

//--- testbench/ccs_host_model.sv
// clock pins of the far party: master clock, bit clock and frame clock
// assumes run controls from the bench; a stopped master clock rests at 0, stopped bit and frame clocks hold their level
`timescale 1ns/100ps
`default_nettype none
module ccs_host_model (
    // run controls from the bench
    input  wire logic mclk_run_in,
    input  wire logic slv_run_in,
    // clock pins toward the device
    output logic      mclk_out,
    output logic      bclk_out,
    output logic      lrck_out
);
    // ****************************************
    // clock generators
    // ****************************************
    int bcnt = 0;
    initial begin
        mclk_out = 1'b0;
        bclk_out = 1'b0;
        lrck_out = 1'b0;
    end
    // master clock, 24 ns period, held still while stopped
    always begin
        #12;
        mclk_out = mclk_run_in ? ~mclk_out : 1'b0;
    end
    // bit clock 64 ns, frame clock every 32 bit clocks
    always begin
        #32;
        if (slv_run_in) begin
            bclk_out = ~bclk_out;
            bcnt = (bclk_out == 1'b0) ? bcnt + 1 : bcnt;
            if (bcnt == 32) begin
                bcnt = 0;
                lrck_out = ~lrck_out;
            end
        end
    end
endmodule // ccs_host_model
`default_nettype wire

//--- testbench/testbench.sv
// bench for ccs_top: bus master, reference copy of registers, clock host
// assumes ccs_host_model supplies the far-party clocks
`timescale 1ns/100ps
`default_nettype none
module testbench;
    // ****************************************
    // signals and instances
    // ****************************************
    logic        clk_sys_in = 1'b0;
    logic        rst_n_in = 1'b0;
    logic [4:0]  avs_address_in = 5'h00;
    logic        avs_read_in = 1'b0;
    logic        avs_write_in = 1'b0;
    logic [31:0] avs_writedata_in = 32'h0000_0000;
    logic [31:0] avs_readdata_out;
    logic        avs_waitrequest_out;
    logic        pin_n = 1'b0;
    logic        mclk_run = 1'b0;
    logic        slv_run = 1'b0;
    logic        mclk, hb, hl, bclk_out, bclk_oe_out, lrck_out, lrck_oe_out, master_clock_output, norm_op;
    wire logic   bclk_w = bclk_oe_out ? bclk_out : hb;
    wire logic   lrck_w = lrck_oe_out ? lrck_out : hl;
    int          error_cnt = 0;
    int          n_tests = 0;
    int          exp_reg [6] = '{default: 0};
    int          msk [6] = '{32'h0000_001f, 32'h0000_00ff, 32'h0000_003f, -1, 0, 0};
    bit          core_ok = 1'b0;
    logic [31:0] q;
    int          a, b;
    always #2.5 clk_sys_in = ~clk_sys_in;
    ccs_top #(.CORE_WAIT_CYC(20), .REF_UP_CYC(50), .PLL_LOCK_CYC(30), .LOCK_MAX_CYC(60))
    u_ccs_top (.clk_sys_in(clk_sys_in), .rst_n_in(rst_n_in), .avs_address_in(avs_address_in),
        .avs_read_in(avs_read_in), .avs_write_in(avs_write_in),
        .avs_writedata_in(avs_writedata_in), .avs_readdata_out(avs_readdata_out),
        .avs_waitrequest_out(avs_waitrequest_out), .chip_shutdown_pin_n_in(pin_n),
        .master_clock_input_in(mclk), .bclk_in(bclk_w), .lrck_in(lrck_w),
        .bclk_out(bclk_out), .bclk_oe_out(bclk_oe_out), .lrck_out(lrck_out),
        .lrck_oe_out(lrck_oe_out), .master_clock_output_out(master_clock_output),
        .normal_operation_out(norm_op));
    ccs_host_model u_ccs_host_model (.mclk_run_in(mclk_run), .slv_run_in(slv_run),
        .mclk_out(mclk), .bclk_out(hb), .lrck_out(hl));
    // ****************************************
    // tasks
    // ****************************************
    task automatic results();
        $display("checks %0d errors %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp) begin
            error_cnt++;
            $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // one access, held until waitrequest is seen low at an edge
    task automatic bus(input logic wr, input logic [4:0] ad, input logic [31:0] d);
        int n;
        n = 0;
        avs_address_in <= ad;
        avs_writedata_in <= d;
        avs_write_in <= wr;
        avs_read_in <= ~wr;
        do begin
            @(posedge clk_sys_in);
            n++;
        end while (avs_waitrequest_out !== 1'b0 && n < 40);
        q = avs_readdata_out;
        avs_write_in <= 1'b0;
        avs_read_in <= 1'b0;
        if (avs_waitrequest_out !== 1'b0) chk("bus timeout", 1, 0);
        @(posedge clk_sys_in);
    endtask
    // write and keep the reference copy in step
    task automatic wr(input int i, input logic [31:0] d);
        bus(1'b1, 5'(i * 4), d);
        if (core_ok) exp_reg[i] = d & msk[i];
    endtask
    task automatic rdc(input int i);
        bus(1'b0, 5'(i * 4), 32'h0000_0000);
        chk($sformatf("reg %0d", i), q, exp_reg[i]);
    endtask
    task automatic stc(input string nm, input logic [31:0] m, input logic [31:0] e);
        bus(1'b0, 5'h10, 32'h0000_0000);
        chk(nm, q & m, e);
    endtask
    task automatic wst(input int bitn);
        int n;
        n = 0;
        do begin
            bus(1'b0, 5'h10, 32'h0000_0000);
            n++;
        end while (q[bitn] !== 1'b1 && n < 40);
        chk("status wait", q[bitn], 1'b1);
    endtask
    // count edges of bit clock and master clock output
    task automatic cnt_tog(input int cyc, output int nb, output int nm);
        logic pb, pm;
        nb = 0;
        nm = 0;
        pb = bclk_out;
        pm = master_clock_output;
        repeat (cyc) begin
            @(posedge clk_sys_in);
            nb += (bclk_out != pb);
            nm += (master_clock_output != pm);
            pb = bclk_out;
            pm = master_clock_output;
        end
    endtask
    // ****************************************
    // main sequence
    // ****************************************
    initial begin
        void'($urandom(76977));
        repeat (8) @(posedge clk_sys_in);
        rst_n_in <= 1'b1;
        mclk_run <= 1'b1;
        repeat (10) @(posedge clk_sys_in);
        pin_n <= 1'b1;
        wr(0, 32'h0000_0001);
        rdc(0);
        stc("core wait", 32'h0000_0001, 32'h0000_0000);
        repeat (30) @(posedge clk_sys_in);
        core_ok = 1'b1;
        stc("core up", 32'h0000_0001, 32'h0000_0001);
        for (int i = 0; i < 6; i++) begin
            if (i != 4) wr(i, $urandom());
            if (i != 4) rdc(i);
        end
        wr(0, 32'h0000_0000);
        wr(1, $urandom() & 32'h0000_00fc);
        wr(0, 32'h0000_0001);
        stc("refs first", 32'h0000_001c, 32'h0000_0000);
        wst(1);
        mclk_run <= 1'b0;
        repeat (2200) @(posedge clk_sys_in);
        wr(0, 32'h0000_000f);
        repeat (100) @(posedge clk_sys_in);
        stc("no reference", 32'h0000_001c, 32'h0000_0000);
        mclk_run <= 1'b1;
        a = 0;
        b = 0;
        while (norm_op !== 1'b1 && a < 70) begin
            @(posedge clk_sys_in);
            if (norm_op !== 1'b1) b = b | bclk_out | lrck_out | (bclk_oe_out !== 1'b1);
            a++;
        end
        chk("lock in time", norm_op, 1'b1);
        chk("low before lock", b, 0);
        cnt_tog(80, a, b);
        chk("bclk rate", a, 10);
        chk("master_clock_output rate", b, 40);
        wr(0, 32'h0000_000b);
        repeat (2) @(posedge clk_sys_in);
        cnt_tog(40, a, b);
        chk("master_clock_output off", b, 0);
        wr(0, 32'h0000_0001);
        repeat (2200) @(posedge clk_sys_in);
        chk("slave oe", bclk_oe_out, 1'b0);
        chk("slave wait", norm_op, 1'b0);
        slv_run <= 1'b1;
        a = 0;
        while (norm_op !== 1'b1 && a < 3000) begin
            @(posedge clk_sys_in);
            a++;
        end
        chk("slave run", norm_op, 1'b1);
        wr(1, 32'h0000_0001);
        wr(0, 32'h0000_0003);
        repeat (60) @(posedge clk_sys_in);
        stc("bclk ref lock", 32'h0000_071c, 32'h0000_011c);
        wr(1, 32'h0000_0000);
        stc("mclk ref lock", 32'h0000_071c, 32'h0000_021c);
        slv_run <= 1'b0;
        wr(0, 32'h0000_0008);
        cnt_tog(40, a, b);
        chk("ext master hold", a, 0);
        wr(0, 32'h0000_0018);
        repeat (20) @(posedge clk_sys_in);
        cnt_tog(200, a, b);
        chk("ext master oe", bclk_oe_out, 1'b1);
        chk("ext master lrck oe", lrck_oe_out, 1'b1);
        chk("ext master bclk", a > 10, 1'b1);
        pin_n <= 1'b0;
        repeat (10) @(posedge clk_sys_in);
        core_ok = 1'b0;
        exp_reg = '{default: 0};
        for (int i = 0; i < 4; i++) rdc(i);
        chk("shutdown oe", bclk_oe_out, 1'b0);
        results();
    end
endmodule // testbench
`default_nettype wire
